// ===== hdl/asdm_consts.vh
`ifndef ASDM_CONSTS_VH
`define ASDM_CONSTS_VH
// Sample width setting codes.
`define ASDM_W8      2'h0
`define ASDM_W16     2'h1
`define ASDM_W24     2'h2
// Channel setting codes.
`define ASDM_STEREO  2'h0
`define ASDM_LEFT    2'h1
`define ASDM_RIGHT   2'h2
// Memory words are 32 bits wide, so addresses step by four bytes.
`define ASDM_STEP    32'h4
// Width of the shared buffer word count.
`define ASDM_CW      14
// Index of the last sample lane in a word for each width.
`define ASDM_LAST8   2'h3
`define ASDM_LAST16  2'h1
`define ASDM_LAST24  2'h0
// Sign bit of a 24-bit sample and the lane masks.
`define ASDM_SIGN24  23
`define ASDM_MASK8   32'h000000FF
`define ASDM_MASK16  32'h0000FFFF
// Two-entry frame buffer depth.
`define ASDM_BUF_FULL 2'h2
`endif

// ===== hdl/asdm_sample_mover.v
`timescale 1ns/1ps
`include "asdm_consts.vh"

// Behaviour
// - Transmit words are read only while transmit is enabled, receive words written only while receive is enabled.
// - Each software pointer is copied into a working pointer whenever the word count has been moved.
// - Each copy of a pointer into its working pointer raises that direction's pointer-taken pulse, except a start copy while that direction is disabled.
// - One word count setting sizes both the transmit and the receive buffer.
// - The word count counts 32-bit memory words in both directions.
// - A word holds four 8-bit, two 16-bit or one right-placed sign-extended 24-bit sample.
// - Stereo samples sit in memory as left-then-right pairs, alike for transmit and receive.
// - Mono receive stores only the selected channel's sample and drops the other.
// - Mono transmit sends each fetched sample in both the left and the right half.
// - 8-bit samples pack four to a word, earliest in the lowest byte.
// - 16-bit stereo puts left in bits 15..0 and right in bits 31..16 of one word.
// - 16-bit mono puts two samples per word, earlier in the lower half.
// - 24-bit stereo takes two words per frame, left first, sign extended above bit 23.
// - Stop ceases transfers, halts the master clock and then pulses the stopped event.
module asdm_sample_mover (
  // Clock and reset.
  input  wire                 clk_in,
  input  wire                 reset_n_in,
  // Settings and commands from software.
  input  wire                 enable_in,
  input  wire                 transmit_enable_setting_in,
  input  wire                 receive_enable_setting_in,
  input  wire                 mck_enable_setting_in,
  input  wire [1:0]           sample_width_setting_in,
  input  wire [1:0]           channel_setting_in,
  input  wire [31:0]          tx_buffer_pointer_in,
  input  wire [31:0]          rx_buffer_pointer_in,
  input  wire [`ASDM_CW-1:0]  buffer_word_count_in,
  input  wire                 start_in,
  input  wire                 stop_in,
  // Events and status.
  output wire                 tx_pointer_taken_event_out,
  output wire                 rx_pointer_taken_event_out,
  output wire                 stopped_event_out,
  output wire                 running_out,
  output wire                 mck_run_out,
  // Memory master port.
  output wire                 mem_req_out,
  output wire                 mem_write_out,
  output wire [31:0]          mem_addr_out,
  output wire [31:0]          mem_wdata_out,
  input  wire                 mem_accept_in,
  input  wire                 mem_rvalid_in,
  input  wire [31:0]          mem_rdata_in,
  // Transmit frames towards the shifter.
  output wire                 tx_frame_valid_out,
  input  wire                 tx_frame_ready_in,
  output wire [23:0]          tx_left_out,
  output wire [23:0]          tx_right_out,
  // Receive frames from the shifter.
  input  wire                 rx_frame_valid_in,
  output wire                 rx_frame_ready_out,
  input  wire [23:0]          rx_left_in,
  input  wire [23:0]          rx_right_in
);

  // Memory port states, one-hot.
  localparam [2:0] M_IDLE = 3'h1;
  localparam [2:0] M_REQ  = 3'h2;
  localparam [2:0] M_READ = 3'h4;

  reg [2:0]          mst_reg;
  reg                run_reg;
  reg                stopping_reg;
  reg                stop_evt_reg;
  reg                tx_evt_reg;
  reg                rx_evt_reg;
  reg                req_reg;
  reg                wr_reg;
  reg [31:0]         addr_reg;
  reg [31:0]         wdata_reg;
  reg [31:0]         tx_addr_reg;
  reg [31:0]         rx_addr_reg;
  reg [`ASDM_CW-1:0] tx_cnt_reg;
  reg [`ASDM_CW-1:0] rx_cnt_reg;
  reg [31:0]         tx_word_reg;
  reg                tx_full_reg;
  reg [1:0]          tx_idx_reg;
  reg                tx_phase_reg;
  reg [23:0]         tx_left_reg;
  reg [31:0]         rx_word_reg;
  reg                rx_pend_reg;
  reg [1:0]          rx_idx_reg;
  reg                rx_phase_reg;
  reg                rx_hold_reg;
  reg [23:0]         rx_l_reg;
  reg [23:0]         rx_r_reg;
  reg [23:0]         buf_l_reg [0:1];
  reg [23:0]         buf_r_reg [0:1];
  reg                buf_wp_reg;
  reg                buf_rp_reg;
  reg [1:0]          buf_cnt_reg;

  // Index of the last sample lane in a word for the configured width.
  function [1:0] last_lane;
    input [1:0] w;
    begin
      case (w)
        `ASDM_W8:  last_lane = `ASDM_LAST8;
        `ASDM_W16: last_lane = `ASDM_LAST16;
        default:   last_lane = `ASDM_LAST24;
      endcase
    end
  endfunction

  // Pull one sample out of a memory word, right-justified.
  function [23:0] extract;
    input [31:0] word;
    input [1:0]  idx;
    input [1:0]  w;
    reg   [31:0] t;
    begin
      t = 32'h00000000;
      case (w)
        `ASDM_W8: begin
          t = word >> {idx, 3'h0};
          extract = {16'h0000, t[7:0]};
        end
        `ASDM_W16: begin
          t = word >> {idx[0], 4'h0};
          extract = {8'h00, t[15:0]};
        end
        default: extract = word[23:0];
      endcase
    end
  endfunction

  // Place one sample into its lane of a memory word.
  function [31:0] insert;
    input [31:0] word;
    input [1:0]  idx;
    input [1:0]  w;
    input [23:0] s;
    reg   [31:0] m;
    begin
      m = 32'h00000000;
      case (w)
        `ASDM_W8: begin
          m = `ASDM_MASK8 << {idx, 3'h0};
          insert = (word & ~m) | ({24'h000000, s[7:0]} << {idx, 3'h0});
        end
        `ASDM_W16: begin
          m = `ASDM_MASK16 << {idx[0], 4'h0};
          insert = (word & ~m) | ({16'h0000, s[15:0]} << {idx[0], 4'h0});
        end
        default: insert = {{8{s[`ASDM_SIGN24]}}, s};
      endcase
    end
  endfunction

  wire        start_go = start_in & enable_in & ~run_reg;
  wire        tx_go    = run_reg & ~stopping_reg & transmit_enable_setting_in;
  wire        rx_go    = run_reg & ~stopping_reg & receive_enable_setting_in;
  wire        stereo   = (channel_setting_in == `ASDM_STEREO);
  wire [1:0]  last     = last_lane(sample_width_setting_in);
  wire        done     = (mst_reg == M_REQ) & mem_accept_in;
  wire        tx_load  = (mst_reg == M_READ) & mem_rvalid_in;
  wire        rx_done  = done & wr_reg;
  wire        buf_in_rdy = (buf_cnt_reg != `ASDM_BUF_FULL);
  wire        buf_pop  = tx_frame_valid_out & tx_frame_ready_in;
  wire [23:0] tx_cur   = extract(tx_word_reg, tx_idx_reg, sample_width_setting_in);
  wire        tx_left_phase = stereo & ~tx_phase_reg;
  wire        tx_step  = tx_go & tx_full_reg & (tx_left_phase | buf_in_rdy);
  wire        buf_push = tx_step & ~tx_left_phase;
  wire [23:0] rx_cur   = rx_phase_reg ? rx_r_reg : rx_l_reg;
  wire        rx_step  = rx_go & rx_hold_reg & ~rx_pend_reg;

  // Memory sequencer, run control and the working pointers; receive
  // writes win over transmit reads because a late write loses audio.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mst_reg      <= M_IDLE;
      run_reg      <= 1'b0;
      stopping_reg <= 1'b0;
      stop_evt_reg <= 1'b0;
      tx_evt_reg   <= 1'b0;
      rx_evt_reg   <= 1'b0;
      req_reg      <= 1'b0;
      wr_reg       <= 1'b0;
      addr_reg     <= 32'h00000000;
      wdata_reg    <= 32'h00000000;
      tx_addr_reg  <= 32'h00000000;
      rx_addr_reg  <= 32'h00000000;
      tx_cnt_reg   <= {`ASDM_CW{1'b0}};
      rx_cnt_reg   <= {`ASDM_CW{1'b0}};
    end else begin
      tx_evt_reg   <= 1'b0;
      rx_evt_reg   <= 1'b0;
      stop_evt_reg <= 1'b0;
      if (start_go) begin
        run_reg     <= 1'b1;
        tx_addr_reg <= tx_buffer_pointer_in;
        rx_addr_reg <= rx_buffer_pointer_in;
        tx_cnt_reg  <= {`ASDM_CW{1'b0}};
        rx_cnt_reg  <= {`ASDM_CW{1'b0}};
        tx_evt_reg  <= transmit_enable_setting_in;
        rx_evt_reg  <= receive_enable_setting_in;
      end
      if (stop_in & run_reg) begin
        stopping_reg <= 1'b1;
      end
      // The stopped pulse waits until the memory port has gone quiet.
      if (stopping_reg & (mst_reg == M_IDLE)) begin
        run_reg      <= 1'b0;
        stopping_reg <= 1'b0;
        stop_evt_reg <= 1'b1;
      end
      case (mst_reg)
        M_IDLE: begin
          if (rx_go & rx_pend_reg) begin
            req_reg   <= 1'b1;
            wr_reg    <= 1'b1;
            addr_reg  <= rx_addr_reg;
            wdata_reg <= rx_word_reg;
            mst_reg   <= M_REQ;
          end else if (tx_go & ~tx_full_reg) begin
            req_reg  <= 1'b1;
            wr_reg   <= 1'b0;
            addr_reg <= tx_addr_reg;
            mst_reg  <= M_REQ;
          end
        end
        M_REQ: begin
          if (mem_accept_in) begin
            req_reg <= 1'b0;
            mst_reg <= wr_reg ? M_IDLE : M_READ;
            // Both directions count words against the one shared setting.
            if (wr_reg) begin
              if (rx_cnt_reg + 1'b1 >= buffer_word_count_in) begin
                rx_addr_reg <= rx_buffer_pointer_in;
                rx_cnt_reg  <= {`ASDM_CW{1'b0}};
                rx_evt_reg  <= 1'b1;
              end else begin
                rx_addr_reg <= rx_addr_reg + `ASDM_STEP;
                rx_cnt_reg  <= rx_cnt_reg + 1'b1;
              end
            end else begin
              if (tx_cnt_reg + 1'b1 >= buffer_word_count_in) begin
                tx_addr_reg <= tx_buffer_pointer_in;
                tx_cnt_reg  <= {`ASDM_CW{1'b0}};
                tx_evt_reg  <= 1'b1;
              end else begin
                tx_addr_reg <= tx_addr_reg + `ASDM_STEP;
                tx_cnt_reg  <= tx_cnt_reg + 1'b1;
              end
            end
          end
        end
        M_READ: begin
          if (mem_rvalid_in) begin
            mst_reg <= M_IDLE;
          end
        end
        default: begin
          req_reg <= 1'b0;
          mst_reg <= M_IDLE;
        end
      endcase
    end
  end

  // Transmit unpacking: one sample per step, a stereo frame takes a left
  // then a right step, and a mono sample goes to both halves.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_word_reg  <= 32'h00000000;
      tx_full_reg  <= 1'b0;
      tx_idx_reg   <= 2'h0;
      tx_phase_reg <= 1'b0;
      tx_left_reg  <= 24'h000000;
    end else if (start_go) begin
      tx_full_reg  <= 1'b0;
      tx_idx_reg   <= 2'h0;
      tx_phase_reg <= 1'b0;
    end else if (tx_load) begin
      tx_word_reg <= mem_rdata_in;
      tx_full_reg <= 1'b1;
      tx_idx_reg  <= 2'h0;
    end else if (tx_step) begin
      if (tx_left_phase) begin
        tx_left_reg  <= tx_cur;
        tx_phase_reg <= 1'b1;
      end else begin
        tx_phase_reg <= 1'b0;
      end
      if (tx_idx_reg == last) begin
        tx_full_reg <= 1'b0;
        tx_idx_reg  <= 2'h0;
      end else begin
        tx_idx_reg <= tx_idx_reg + 2'h1;
      end
    end
  end

  // Two-entry frame buffer; a stalled shifter fills it and then holds
  // the unpacker, so no fetched sample is dropped.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      buf_wp_reg     <= 1'b0;
      buf_rp_reg     <= 1'b0;
      buf_cnt_reg    <= 2'h0;
      buf_l_reg[0]   <= 24'h000000;
      buf_l_reg[1]   <= 24'h000000;
      buf_r_reg[0]   <= 24'h000000;
      buf_r_reg[1]   <= 24'h000000;
    end else if (start_go) begin
      buf_wp_reg  <= 1'b0;
      buf_rp_reg  <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_l_reg[buf_wp_reg] <= stereo ? tx_left_reg : tx_cur;
        buf_r_reg[buf_wp_reg] <= tx_cur;
        buf_wp_reg <= ~buf_wp_reg;
      end
      if (buf_pop) begin
        buf_rp_reg <= ~buf_rp_reg;
      end
      buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Receive packing: a frame is held, then its kept samples are placed
  // lane by lane; a full word waits for the memory port.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_word_reg  <= 32'h00000000;
      rx_pend_reg  <= 1'b0;
      rx_idx_reg   <= 2'h0;
      rx_phase_reg <= 1'b0;
      rx_hold_reg  <= 1'b0;
      rx_l_reg     <= 24'h000000;
      rx_r_reg     <= 24'h000000;
    end else if (start_go) begin
      rx_pend_reg <= 1'b0;
      rx_idx_reg  <= 2'h0;
      rx_hold_reg <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_pend_reg <= 1'b0;
      end
      if (rx_frame_valid_in & rx_frame_ready_out) begin
        rx_l_reg     <= rx_left_in;
        rx_r_reg     <= rx_right_in;
        rx_hold_reg  <= 1'b1;
        rx_phase_reg <= (channel_setting_in == `ASDM_RIGHT);
      end else if (rx_step) begin
        rx_word_reg <= insert(rx_word_reg, rx_idx_reg,
                              sample_width_setting_in, rx_cur);
        if (rx_idx_reg == last) begin
          rx_pend_reg <= 1'b1;
          rx_idx_reg  <= 2'h0;
        end else begin
          rx_idx_reg <= rx_idx_reg + 2'h1;
        end
        // Mono frames end after the kept sample; the other is dropped.
        if (stereo & ~rx_phase_reg) begin
          rx_phase_reg <= 1'b1;
        end else begin
          rx_hold_reg <= 1'b0;
        end
      end
    end
  end

  // Output assignments.
  assign tx_pointer_taken_event_out = tx_evt_reg;
  assign rx_pointer_taken_event_out = rx_evt_reg;
  assign stopped_event_out          = stop_evt_reg;
  assign running_out                = run_reg;
  assign mck_run_out                = run_reg & ~stopping_reg & mck_enable_setting_in;
  assign mem_req_out                = req_reg;
  assign mem_write_out              = wr_reg;
  assign mem_addr_out               = addr_reg;
  assign mem_wdata_out              = wdata_reg;
  // Frames left over from a stopped run stay hidden until the next start flushes them.
  assign tx_frame_valid_out         = run_reg & (buf_cnt_reg != 2'h0);
  assign tx_left_out                = buf_l_reg[buf_rp_reg];
  assign tx_right_out               = buf_r_reg[buf_rp_reg];
  assign rx_frame_ready_out         = rx_go & ~rx_hold_reg;

endmodule

// ===== test/asdm_props.sv
`timescale 1ns/1ps
`include "asdm_consts.vh"

// Port-level watch on the mover; it sees only the top module's pins.
module asdm_props (
  // Clock and reset.
  input wire        clk_in,
  input wire        reset_n_in,
  // Settings and commands.
  input wire        enable_in,
  input wire        transmit_enable_setting_in,
  input wire        receive_enable_setting_in,
  input wire [1:0]  sample_width_setting_in,
  input wire [1:0]  channel_setting_in,
  input wire        start_in,
  input wire        stop_in,
  // Events, status and memory port.
  input wire        tx_pointer_taken_event_out,
  input wire        rx_pointer_taken_event_out,
  input wire        stopped_event_out,
  input wire        running_out,
  input wire        mck_run_out,
  input wire        mem_req_out,
  input wire        mem_write_out,
  input wire [31:0] mem_wdata_out,
  // Transmit frame path.
  input wire        tx_frame_valid_out,
  input wire [23:0] tx_left_out,
  input wire [23:0] tx_right_out
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // A start counts only while enabled and idle, so repeats cannot fake a copy.
  wire start_ok = start_in && enable_in && !running_out;
  // Each direction touches memory only while it is switched on.
  tx_read_gate_a: assert property (
    mem_req_out && !mem_write_out |-> transmit_enable_setting_in)
    else $error("memory read with transmit off");
  rx_write_gate_a: assert property (
    mem_req_out && mem_write_out |-> receive_enable_setting_in)
    else $error("memory write with receive off");
  // A taken start copies the pointers of the enabled directions next cycle.
  tx_start_take_a: assert property (
    start_ok && transmit_enable_setting_in |=> tx_pointer_taken_event_out && running_out)
    else $error("no transmit pointer copy after start");
  rx_start_take_a: assert property (
    start_ok && receive_enable_setting_in |=> rx_pointer_taken_event_out)
    else $error("no receive pointer copy after start");
  // Stop halts the master clock on the next cycle and reports within a bounded wait.
  mck_halt_a: assert property (
    stop_in && running_out |=> !mck_run_out)
    else $error("master clock still running after stop");
  stop_event_a: assert property (
    stop_in && running_out |-> ##[2:60] stopped_event_out)
    else $error("stopped event missing");
  // Mono transmit repeats the fetched sample on both halves of the frame.
  tx_mono_copy_a: assert property (
    tx_frame_valid_out && channel_setting_in != `ASDM_STEREO |-> tx_left_out == tx_right_out)
    else $error("mono frame halves differ");
  // A stored 24-bit sample carries its sign up to bit 31.
  rx_sign_ext_a: assert property (
    mem_req_out && mem_write_out && sample_width_setting_in == `ASDM_W24
      |-> mem_wdata_out[31:24] == {8{mem_wdata_out[23]}})
    else $error("24-bit word not sign extended");
  cover property (stopped_event_out);
  cover property (rx_pointer_taken_event_out && running_out);
  cover property (tx_frame_valid_out && channel_setting_in != `ASDM_STEREO);
endmodule

// ===== test/asdm_mem_model.sv
`timescale 1ns/1ps

// Behavioural data RAM behind the memory port, with an adjustable accept delay.
module asdm_mem_model (
  // Clock and reset.
  input  wire        clk_in,
  input  wire        reset_n_in,
  // Request side.
  input  wire        mem_req_in,
  input  wire        mem_write_in,
  input  wire [31:0] mem_addr_in,
  input  wire [31:0] mem_wdata_in,
  input  wire [3:0]  delay_in,
  // Answer side.
  output reg         mem_accept_out,
  output reg         mem_rvalid_out,
  output reg  [31:0] mem_rdata_out
);
  reg [31:0] mem [0:63];
  reg [3:0]  wait_reg;
  // Read data shows for one cycle, then flips every cycle so a late sample is caught.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_accept_out <= 1'b0;
      mem_rvalid_out <= 1'b0;
      mem_rdata_out  <= 32'h00000000;
      wait_reg       <= 4'h0;
    end else begin
      mem_rvalid_out <= 1'b0;
      mem_rdata_out  <= ~mem_rdata_out;
      if (mem_accept_out) begin
        mem_accept_out <= 1'b0;
        wait_reg       <= 4'h0;
        if (mem_write_in) begin
          mem[mem_addr_in[7:2]] <= mem_wdata_in;
        end else begin
          mem_rvalid_out <= 1'b1;
          mem_rdata_out  <= mem[mem_addr_in[7:2]];
        end
      end else if (mem_req_in) begin
        if (wait_reg == delay_in) begin
          mem_accept_out <= 1'b1;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule

// ===== test/test_asdm_sample_mover.sv
`timescale 1ns/1ps
`include "asdm_consts.vh"

module test_asdm_sample_mover;
  reg         clk_in = 1'b0, reset_n_in = 1'b0, enable_in = 1'b0;
  reg         transmit_enable_setting_in = 1'b1, receive_enable_setting_in = 1'b1;
  reg  [1:0]  sample_width_setting_in = 2'h0, channel_setting_in = 2'h0;
  reg  [31:0] tx_buffer_pointer_in = 32'h00000000, rx_buffer_pointer_in = 32'h00000080;
  reg  [13:0] buffer_word_count_in = 14'h0002;
  reg         start_in = 1'b0, stop_in = 1'b0, tx_frame_ready_in = 1'b0, rx_frame_valid_in = 1'b0;
  reg  [23:0] rx_left_in = 24'h000000, rx_right_in = 24'h000000;
  reg  [3:0]  delay = 4'h0;
  wire        tx_pointer_taken_event_out, rx_pointer_taken_event_out, stopped_event_out;
  wire        running_out, mck_run_out, mem_req_out, mem_write_out, mem_accept_in;
  wire        mem_rvalid_in, tx_frame_valid_out, rx_frame_ready_out;
  wire [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
  wire [23:0] tx_left_out, tx_right_out;
  integer     n_mismatch = 0, num_checks = 0, tx_ev = 0, rx_ev = 0;
  integer     i, f, k, nf, bw, sp;

  asdm_sample_mover u_asdm_sample_mover (
    .clk_in, .reset_n_in, .enable_in, .transmit_enable_setting_in, .receive_enable_setting_in,
    .mck_enable_setting_in(1'b1), .sample_width_setting_in, .channel_setting_in,
    .tx_buffer_pointer_in, .rx_buffer_pointer_in, .buffer_word_count_in, .start_in, .stop_in,
    .tx_pointer_taken_event_out, .rx_pointer_taken_event_out, .stopped_event_out,
    .running_out, .mck_run_out, .mem_req_out, .mem_write_out, .mem_addr_out, .mem_wdata_out,
    .mem_accept_in, .mem_rvalid_in, .mem_rdata_in, .tx_frame_valid_out, .tx_frame_ready_in,
    .tx_left_out, .tx_right_out, .rx_frame_valid_in, .rx_frame_ready_out, .rx_left_in,
    .rx_right_in);
  asdm_mem_model u_asdm_mem_model (
    .clk_in, .reset_n_in, .mem_req_in(mem_req_out), .mem_write_in(mem_write_out),
    .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .delay_in(delay),
    .mem_accept_out(mem_accept_in), .mem_rvalid_out(mem_rvalid_in),
    .mem_rdata_out(mem_rdata_in));

  // Free-running clock; pointer-taken pulses are tallied at every rising edge.
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    tx_ev = tx_ev + tx_pointer_taken_event_out;
    rx_ev = rx_ev + rx_pointer_taken_event_out;
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (n_mismatch == 0 && num_checks > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask

  // Transmit word j of the stream, and the sample patterns both sides use.
  function [31:0] twd(input [31:0] j);
    twd = 32'hF08C7A35 + j * 32'h13579BDF;
  endfunction
  function [23:0] txs(input [31:0] n);
    txs = (twd(n / sp) >> (bw * (n % sp))) & ((32'h1 << bw) - 1);
  endfunction
  function [23:0] rxs(input [31:0] n);
    rxs = (24'hC35A81 + n * 24'h010305) & ((32'h1 << bw) - 1);
  endfunction
  // Expected receive word: kept samples packed upward from bit 0.
  function [31:0] rxw(input [31:0] w);
    integer j;
    begin
      rxw = 32'h00000000;
      for (j = 0; j < sp; j = j + 1) begin
        rxw = rxw | (rxs(channel_setting_in == `ASDM_STEREO ? w * sp + j
          : 2 * (w * sp + j) + (channel_setting_in == `ASDM_RIGHT)) << (bw * j));
      end
      if (bw == 24) begin
        rxw[31:24] = {8{rxw[23]}};
      end
    end
  endfunction

  // One-cycle command pulse: start when is_stop is low, stop otherwise.
  task cmd(input is_stop);
    begin
      start_in = !is_stop;
      stop_in = is_stop;
      @(negedge clk_in);
      start_in = 1'b0;
      stop_in = 1'b0;
    end
  endtask
  task halt;
    begin
      cmd(1'b1);
      for (i = 0; i < 100 && running_out !== 1'b0; i = i + 1) @(negedge clk_in);
      check(running_out, 0);
    end
  endtask

  // Two buffers of two words each way; pointers move after start to catch the reload.
  task run_case(input [1:0] w, input [1:0] c, input [3:0] d);
    begin
      sample_width_setting_in = w;
      channel_setting_in = c;
      delay = d;
      bw = 8 * (w + 1);
      sp = 4 / (w + 1);
      nf = (c == `ASDM_STEREO) ? 2 * sp : 4 * sp;
      tx_buffer_pointer_in = 32'h00000000;
      rx_buffer_pointer_in = 32'h00000080;
      for (i = 0; i < 4; i = i + 1) begin
        u_asdm_mem_model.mem[i < 2 ? i : i + 6] = twd(i);
        u_asdm_mem_model.mem[32 + (i < 2 ? i : i + 6)] = 32'h00000000;
      end
      tx_ev = 0;
      rx_ev = 0;
      cmd(1'b0);
      tx_buffer_pointer_in = 32'h00000020;
      rx_buffer_pointer_in = 32'h000000A0;
      fork
        begin
          rx_frame_valid_in = 1'b1;
          for (i = 0; i < nf; i = i + 1) begin
            rx_left_in = rxs(2 * i);
            rx_right_in = rxs(2 * i + 1);
            while (rx_frame_ready_out !== 1'b1) @(negedge clk_in);
            @(negedge clk_in);
          end
          rx_frame_valid_in = 1'b0;
        end
        begin
          f = 0;
          k = 0;
          while (f < nf) begin
            @(negedge clk_in);
            k = k + 1;
            tx_frame_ready_in = (k > 12) && (k % 3 != 0);
            if (tx_frame_valid_out === 1'b1 && tx_frame_ready_in) begin
              check(tx_left_out, txs(c == `ASDM_STEREO ? 2 * f : f));
              check(tx_right_out, txs(c == `ASDM_STEREO ? 2 * f + 1 : f));
              f = f + 1;
            end
          end
          @(negedge clk_in);
          tx_frame_ready_in = 1'b0;
        end
      join
      for (i = 0; i < 200 && rx_ev < 3; i = i + 1) @(negedge clk_in);
      halt;
      check(rx_ev, 3);
      check(tx_ev > 1, 1);
      for (k = 0; k < 4; k = k + 1) begin
        check(u_asdm_mem_model.mem[32 + (k < 2 ? k : k + 6)], rxw(k));
      end
    end
  endtask

  initial begin
    repeat (10) @(negedge clk_in);
    reset_n_in = 1'b1;
    // A start while the module is disabled is ignored.
    cmd(1'b0);
    check(running_out, 0);
    // With both directions off a run raises no pointer-taken pulse and opens no receive path.
    enable_in = 1'b1;
    transmit_enable_setting_in = 1'b0;
    receive_enable_setting_in = 1'b0;
    tx_ev = 0;
    rx_ev = 0;
    cmd(1'b0);
    repeat (20) @(negedge clk_in);
    check(tx_ev + rx_ev, 0);
    check(rx_frame_ready_out, 0);
    halt;
    transmit_enable_setting_in = 1'b1;
    receive_enable_setting_in = 1'b1;
    run_case(`ASDM_W16, `ASDM_STEREO, 4'h0);
    run_case(`ASDM_W8, `ASDM_STEREO, 4'h3);
    run_case(`ASDM_W16, `ASDM_LEFT, 4'h1);
    run_case(`ASDM_W8, `ASDM_RIGHT, 4'h0);
    run_case(`ASDM_W24, `ASDM_STEREO, 4'h2);
    run_case(`ASDM_W24, `ASDM_LEFT, 4'h0);
    report_and_stop;
  end

  // Six short runs need a few hundred cycles; fifty thousand means a hang.
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
endmodule

bind asdm_sample_mover asdm_props u_asdm_props (
  .clk_in, .reset_n_in, .enable_in, .transmit_enable_setting_in, .receive_enable_setting_in,
  .sample_width_setting_in, .channel_setting_in, .start_in, .stop_in,
  .tx_pointer_taken_event_out, .rx_pointer_taken_event_out, .stopped_event_out, .running_out,
  .mck_run_out, .mem_req_out, .mem_write_out, .mem_wdata_out, .tx_frame_valid_out,
  .tx_left_out, .tx_right_out);
